// ### logic/port_statistics_counters.sv
`timescale 1ns/100ps
`default_nettype none
// Statistics counters for two network ports plus four drop counters.
module port_statistics_counters
    import stat_pkg::*;
(
    // Clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      reset,
    // Receive frame summary per port, one-cycle strobe
    input  wire logic [PORTS-1:0]          rx_done,
    input  wire logic [PORTS*OCT_W-1:0]    rx_len,
    input  wire logic [PORTS-1:0]          rx_crc_ok,
    input  wire logic [PORTS-1:0]          rx_odd_bits,
    input  wire logic [PORTS-1:0]          rx_sym_err,
    input  wire logic [PORTS-1:0]          rx_bcast,
    input  wire logic [PORTS-1:0]          rx_mcast,
    input  wire logic [PORTS-1:0]          rx_pause_da,
    input  wire logic [PORTS*16-1:0]       rx_type,
    input  wire logic [PORTS*16-1:0]       rx_opcode,
    // Transmit events per port, one-cycle strobes
    input  wire logic [PORTS-1:0]          tx_done,
    input  wire logic [PORTS*OCT_W-1:0]    tx_len,
    input  wire logic [PORTS-1:0]          tx_pause,
    input  wire logic [PORTS-1:0]          tx_bcast,
    input  wire logic [PORTS-1:0]          tx_mcast,
    input  wire logic [PORTS-1:0]          tx_late_hit,
    input  wire logic [PORTS-1:0]          tx_deferred,
    input  wire logic [PORTS-1:0]          tx_collision,
    input  wire logic [PORTS-1:0]          half_duplex,
    input  wire logic [PORTS-1:0]          tx_abandoned,
    input  wire logic [PORTS*4-1:0]        tx_hits,
    // Drop strobes per port
    input  wire logic [PORTS-1:0]          tx_drop,
    input  wire logic [PORTS-1:0]          rx_drop,
    // Indirect access port
    input  wire logic                      ctrl_wr,
    input  wire logic [15:0]               ctrl_wdata,
    input  wire logic                      high_rd,
    input  wire logic                      low_rd,
    output logic [15:0]                    indirect_data_high_half,
    output logic [15:0]                    indirect_data_low_half
);
    localparam int NCNT = PORTS*CNT_PER_PORT;

    logic [CNT_W-1:0]       inc    [NCNT];
    logic [CNT_W-1:0]       val    [NCNT];
    logic [NCNT-1:0]        ovf;
    logic [NCNT-1:0]        clr;
    logic [DROP_W-1:0]      drop_q [2*PORTS];
    logic [ADDR_W-1:0]      addr_q;
    logic                   pending_q;
    logic                   valid_q;
    logic [CNT_W-1:0]       snap_q;
    logic                   snap_ovf_q;
    logic                   is_port_q;
    logic [ADDR_W-1:0]      wr_addr;
    logic                   wr_read;

    assign wr_addr = ctrl_wdata[ADDR_W-1:0];
    assign wr_read = ctrl_wr && ctrl_wdata[15:ADDR_W] == OP_READ_CNT;

    genvar p;
    generate
        for (p = 0; p < PORTS; p++)
        begin : g_port
            logic [19:0]      rx_ev;
            logic [3:0]       hits;
            logic [CNT_W-1:0] pinc [CNT_PER_PORT];
            stat_rx_classify u_cls (
                .frame_done (rx_done[p]),
                .frame_len  (rx_len[p*OCT_W +: OCT_W]),
                .crc_ok     (rx_crc_ok[p]),
                .odd_bits   (rx_odd_bits[p]),
                .sym_err    (rx_sym_err[p]),
                .is_bcast   (rx_bcast[p]),
                .is_mcast   (rx_mcast[p]),
                .pause_da   (rx_pause_da[p]),
                .ether_type (rx_type[p*16 +: 16]),
                .opcode     (rx_opcode[p*16 +: 16]),
                .rx_ev      (rx_ev)
            );
            assign hits = tx_hits[p*4 +: 4];
            always_comb
            begin
                for (int k = 0; k < CNT_PER_PORT; k++)
                    pinc[k] = '0;
                for (int k = 1; k < 20; k++)
                    pinc[k] = CNT_W'(rx_ev[k]);
                pinc[EV_RX_OCT] = rx_ev[EV_RX_OCT] ? CNT_W'(rx_len[p*OCT_W +: OCT_W]) : '0;
                pinc[EV_TX_OCT] = tx_done[p] ? CNT_W'(tx_len[p*OCT_W +: OCT_W]) : '0;
                pinc[EV_TX_LATE]  = CNT_W'(tx_late_hit[p]);
                pinc[EV_TX_PAUSE] = CNT_W'(tx_done[p] && tx_pause[p]);
                pinc[EV_TX_BCAST] = CNT_W'(tx_done[p] && tx_bcast[p]);
                pinc[EV_TX_MCAST] = CNT_W'(tx_done[p] && tx_mcast[p] && !tx_bcast[p]);
                pinc[EV_TX_UCAST] = CNT_W'(tx_done[p] && !tx_mcast[p] && !tx_bcast[p]);
                pinc[EV_TX_DEFER] = CNT_W'(tx_done[p] && tx_deferred[p]);
                pinc[EV_TX_COLL]  = CNT_W'(tx_collision[p] && half_duplex[p]);
                pinc[EV_TX_ABORT] = CNT_W'(tx_abandoned[p]);
                pinc[EV_TX_ONE]   = CNT_W'(tx_done[p] && hits == 4'h1);
                pinc[EV_TX_MANY]  = CNT_W'(tx_done[p] && hits > 4'h1);
            end
            // Each port's process writes only its own array, so the shared one has one driver per entry.
            for (genvar k = 0; k < CNT_PER_PORT; k++)
            begin : g_map
                assign inc[p*CNT_PER_PORT+k] = pinc[k];
            end
        end
    endgenerate

    genvar c;
    generate
        for (c = 0; c < NCNT; c++)
        begin : g_cnt
            assign clr[c] = pending_q && addr_q == ADDR_W'(c);
            stat_counter #(.W(CNT_W)) u_cnt (
                .core_clk (core_clk),
                .reset    (reset),
                .inc      (inc[c]),
                .rd_clear (clr[c]),
                .value_q  (val[c]),
                .ovf_q    (ovf[c])
            );
        end
    endgenerate

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            for (int k = 0; k < 2*PORTS; k++)
                drop_q[k] <= '0;
        end
        else
        begin
            for (int k = 0; k < PORTS; k++)
            begin
                drop_q[k]       <= drop_q[k] + DROP_W'(tx_drop[k]);
                drop_q[PORTS+k] <= drop_q[PORTS+k] + DROP_W'(rx_drop[k]);
            end
        end
    end

    // Command latch; the snapshot is taken one cycle later, which is why valid can read low.
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            addr_q    <= '0;
            pending_q <= 1'b0;
        end
        else
        begin
            pending_q <= wr_read;
            if (wr_read)
                addr_q <= wr_addr;
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            snap_q     <= '0;
            snap_ovf_q <= 1'b0;
            is_port_q  <= 1'b0;
            valid_q    <= 1'b0;
        end
        else if (wr_read)
        begin
            valid_q   <= 1'b0;
            is_port_q <= wr_addr <= PORT_LAST;
        end
        else if (pending_q)
        begin
            valid_q <= 1'b1;
            if (addr_q <= PORT_LAST)
            begin
                snap_q     <= val[addr_q[5:0]];
                snap_ovf_q <= ovf[addr_q[5:0]];
            end
            else
            begin
                snap_ovf_q <= 1'b0;
                unique case (addr_q)
                    DROP_TX1: snap_q <= CNT_W'(drop_q[0]);
                    DROP_TX2: snap_q <= CNT_W'(drop_q[1]);
                    DROP_RX1: snap_q <= CNT_W'(drop_q[2]);
                    DROP_RX2: snap_q <= CNT_W'(drop_q[3]);
                    default:  snap_q <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            indirect_data_high_half <= '0;
        // A new command clears the high half and its flags at once, so stale data never reads as valid.
        else if (wr_read)
            indirect_data_high_half <= '0;
        else if (high_rd || pending_q)
        begin
            if (is_port_q)
                indirect_data_high_half <= {snap_ovf_q, valid_q, snap_q[CNT_W-1:16]};
            else
                indirect_data_high_half <= '0;
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            indirect_data_low_half <= '0;
        else if (high_rd || low_rd || pending_q || wr_read)
            indirect_data_low_half <= snap_q[15:0];
    end

    // Rule checks.
    a_clear_after_read: assert property (@(posedge core_clk) disable iff (reset)
        pending_q && addr_q <= PORT_LAST && inc[addr_q[5:0]] == '0 |=> val[$past(addr_q[5:0])] == '0)
        else $error("read counter not cleared");
    a_snap_value: assert property (@(posedge core_clk) disable iff (reset)
        pending_q && !wr_read && addr_q <= PORT_LAST |=> snap_q == $past(val[addr_q[5:0]]) && valid_q)
        else $error("snapshot mismatch");
    a_valid_low_cmd: assert property (@(posedge core_clk) disable iff (reset)
        wr_read |=> !valid_q ##1 valid_q)
        else $error("valid sequence wrong");
    a_cmd_hides_valid: assert property (@(posedge core_clk) disable iff (reset)
        wr_read |=> indirect_data_high_half[VALID_BIT] == 1'b0)
        else $error("valid flag shown after new command");
    a_drop_no_flags: assert property (@(posedge core_clk) disable iff (reset)
        !is_port_q && $past(high_rd) |-> indirect_data_high_half == '0)
        else $error("drop high half not zero");
    a_drop_kept: assert property (@(posedge core_clk) disable iff (reset)
        pending_q && addr_q == DROP_TX1 && !tx_drop[0] |=> drop_q[0] == $past(drop_q[0]))
        else $error("drop counter changed by read");
    a_drop_count: assert property (@(posedge core_clk) disable iff (reset)
        rx_drop[1] |=> drop_q[3] == $past(drop_q[3]) + 16'h0001)
        else $error("drop counter missed");
    a_coll_half: assert property (@(posedge core_clk) disable iff (reset)
        tx_collision[0] && !half_duplex[0] |-> inc[EV_TX_COLL] == '0)
        else $error("full duplex collision counted");
    a_bin_min: assert property (@(posedge core_clk) disable iff (reset)
        rx_done[0] && rx_len[OCT_W-1:0] == LEN_MIN |-> inc[EV_BIN_FIRST] == 30'h1)
        else $error("64 byte bin missed");
    c_port_read: cover property (@(posedge core_clk) wr_read ##4 high_rd ##2 low_rd);
    c_drop_read: cover property (@(posedge core_clk) wr_read && wr_addr == DROP_RX2);
    c_overflow:  cover property (@(posedge core_clk) |ovf);
endmodule
`default_nettype wire

// ### logic/stat_counter.sv
`timescale 1ns/100ps
`default_nettype none
// One read-clear counter with sticky overflow.
module stat_counter
    import stat_pkg::*;
#(
    parameter int W = CNT_W
)
(
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         reset,
    // Update
    input  wire logic [W-1:0] inc,
    input  wire logic         rd_clear,
    // State
    output logic [W-1:0]      value_q,
    output logic              ovf_q
);
    logic [W:0] sum;
    assign sum = {1'b0, value_q} + {1'b0, inc};
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            value_q <= '0;
        else if (rd_clear)
            value_q <= inc;
        else
            value_q <= sum[W-1:0];
    end
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            ovf_q <= 1'b0;
        else if (!rd_clear && sum[W])
            ovf_q <= 1'b1;
        else if (rd_clear)
            ovf_q <= 1'b0;
    end
endmodule
`default_nettype wire

// ### logic/stat_pkg.sv
// Operation
// - First port counters sit at indirect addresses 0x00 to 0x1F.
// - Second port counters sit at 0x20 to 0x3F, same order.
// - Offset 0x0 sums received low-priority octets, bad frames too; 0x1 reserved.
// - Offset 0x2 counts short good-CRC frames; 0x3 counts short errored frames.
// - Offset 0x4 counts frames over 1536 bytes with good CRC.
// - Offset 0x5 counts frames over 1536 bytes with CRC, alignment or symbol error.
// - Offset 0x6 counts legal-length frames with an invalid data symbol.
// - Bad-CRC frames 64 to 1916 bytes: whole bytes at 0x7, partial at 0x8.
// - Offset 0x9 counts MAC control frames of type 88-08h.
// - Offset 0xA counts fully qualified received pause frames.
// - Good broadcast at 0xB, multicast at 0xC, unicast at 0xD.
// - Received frames of 64 to 1916 bytes binned by length at 0xE to 0x13.
// - Offset 0x14 sums good transmitted octets with pause; 0x15 reserved.
// - Offset 0x16 counts collisions later than 512 bit-times.
// - Tx pause at 0x17; good broadcast, multicast, unicast at 0x18 to 0x1A.
// - Offset 0x1B counts frames whose first attempt was deferred.
// - Offset 0x1C counts half-duplex collisions; 0x1D counts abandoned frames.
// - One-collision successes at 0x1E, multi-collision successes at 0x1F.
// - Four 16-bit drop counters at 0x100, 0x101, 0x103 and 0x104.
// - Drop counters read 16 bits low, no overflow or valid flags.
// - High half bit 31 flags overflow; bit 30 low means re-read.
// - Per-port counters clear on read; drop counters do not.
// - Per-port counters hold a 30-bit value below the flags.
package stat_pkg;
    localparam int          PORTS        = 2;
    localparam int          CNT_PER_PORT = 32;
    localparam int          CNT_W        = 30;
    localparam int          DROP_W       = 16;
    localparam int          ADDR_W       = 10;
    localparam int          OP_W         = 6;
    localparam logic [5:0]  OP_READ_CNT  = 6'h07;
    localparam int          OVF_BIT      = 15;
    localparam int          VALID_BIT    = 14;
    localparam logic [9:0]  PORT2_BASE   = 10'h020;
    localparam logic [9:0]  PORT_LAST    = 10'h03f;
    localparam logic [9:0]  DROP_TX1     = 10'h100;
    localparam logic [9:0]  DROP_TX2     = 10'h101;
    localparam logic [9:0]  DROP_RX1     = 10'h103;
    localparam logic [9:0]  DROP_RX2     = 10'h104;
    // Event bit positions inside each port's 32-wide event vector.
    localparam int          EV_RX_OCT    = 0;
    localparam int          EV_RX_SHORT_OK  = 2;
    localparam int          EV_RX_SHORT_BAD = 3;
    localparam int          EV_RX_LONG_OK   = 4;
    localparam int          EV_RX_LONG_BAD  = 5;
    localparam int          EV_RX_SYM    = 6;
    localparam int          EV_RX_CRC    = 7;
    localparam int          EV_RX_ALIGN  = 8;
    localparam int          EV_RX_CTRL   = 9;
    localparam int          EV_RX_PAUSE  = 10;
    localparam int          EV_RX_BCAST  = 11;
    localparam int          EV_RX_MCAST  = 12;
    localparam int          EV_RX_UCAST  = 13;
    localparam int          EV_BIN_FIRST = 14;
    localparam int          EV_TX_OCT    = 20;
    localparam int          EV_TX_LATE   = 22;
    localparam int          EV_TX_PAUSE  = 23;
    localparam int          EV_TX_BCAST  = 24;
    localparam int          EV_TX_MCAST  = 25;
    localparam int          EV_TX_UCAST  = 26;
    localparam int          EV_TX_DEFER  = 27;
    localparam int          EV_TX_COLL   = 28;
    localparam int          EV_TX_ABORT  = 29;
    localparam int          EV_TX_ONE    = 30;
    localparam int          EV_TX_MANY   = 31;
    localparam logic [10:0] LEN_MIN      = 11'd64;
    localparam logic [10:0] LEN_B        = 11'd128;
    localparam logic [10:0] LEN_C        = 11'd256;
    localparam logic [10:0] LEN_D        = 11'd512;
    localparam logic [10:0] LEN_MAX_BIN  = 11'd1024;
    localparam logic [10:0] LEN_BIN_TOP  = 11'd1916;
    localparam logic [10:0] LEN_LONG     = 11'd1536;
    localparam logic [15:0] TYPE_CTRL    = 16'h8808;
    localparam logic [15:0] OPC_PAUSE    = 16'h0001;
    localparam int          COLL_SLOT    = 512;
    localparam int          OCT_W        = 11;
endpackage

// ### logic/stat_rx_classify.sv
`timescale 1ns/100ps
`default_nettype none
// Turns one received frame summary into a pulse per counter offset.
module stat_rx_classify
    import stat_pkg::*;
(
    // Frame summary, one-cycle strobe
    input  wire logic              frame_done,
    input  wire logic [OCT_W-1:0]  frame_len,
    input  wire logic              crc_ok,
    input  wire logic              odd_bits,
    input  wire logic              sym_err,
    input  wire logic              is_bcast,
    input  wire logic              is_mcast,
    input  wire logic              pause_da,
    input  wire logic [15:0]       ether_type,
    input  wire logic [15:0]       opcode,
    // Events
    output logic [19:0]            rx_ev
);
    logic good;
    logic ctrl;
    logic err;
    logic legal;
    always_comb
    begin
        err   = !crc_ok || odd_bits || sym_err;
        legal = frame_len >= LEN_MIN && frame_len <= LEN_LONG;
        good  = !err && legal;
        ctrl  = ether_type == TYPE_CTRL;
        rx_ev = '0;
        rx_ev[EV_RX_OCT] = frame_done;
        rx_ev[EV_RX_SHORT_OK]  = frame_done && frame_len < LEN_MIN && !err;
        rx_ev[EV_RX_SHORT_BAD] = frame_done && frame_len < LEN_MIN && err;
        rx_ev[EV_RX_LONG_OK]   = frame_done && frame_len > LEN_LONG && !err;
        rx_ev[EV_RX_LONG_BAD]  = frame_done && frame_len > LEN_LONG && err;
        rx_ev[EV_RX_SYM]       = frame_done && legal && sym_err;
        rx_ev[EV_RX_CRC]   = frame_done && !crc_ok && !odd_bits && frame_len >= LEN_MIN && frame_len <= LEN_BIN_TOP;
        rx_ev[EV_RX_ALIGN] = frame_done && !crc_ok && odd_bits && frame_len >= LEN_MIN && frame_len <= LEN_BIN_TOP;
        rx_ev[EV_RX_CTRL]  = frame_done && ctrl;
        rx_ev[EV_RX_PAUSE] = frame_done && ctrl && pause_da && opcode == OPC_PAUSE && frame_len >= LEN_MIN && crc_ok;
        rx_ev[EV_RX_BCAST] = frame_done && good && is_bcast;
        rx_ev[EV_RX_MCAST] = frame_done && good && is_mcast && !is_bcast && !ctrl;
        rx_ev[EV_RX_UCAST] = frame_done && good && !is_mcast && !is_bcast;
        rx_ev[EV_BIN_FIRST]   = frame_done && frame_len == LEN_MIN;
        rx_ev[EV_BIN_FIRST+1] = frame_done && frame_len > LEN_MIN && frame_len < LEN_B;
        rx_ev[EV_BIN_FIRST+2] = frame_done && frame_len >= LEN_B && frame_len < LEN_C;
        rx_ev[EV_BIN_FIRST+3] = frame_done && frame_len >= LEN_C && frame_len < LEN_D;
        rx_ev[EV_BIN_FIRST+4] = frame_done && frame_len >= LEN_D && frame_len < LEN_MAX_BIN;
        rx_ev[EV_BIN_FIRST+5] = frame_done && frame_len >= LEN_MAX_BIN && frame_len <= LEN_BIN_TOP;
    end
endmodule
`default_nettype wire

// ### verification/host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host side of the indirect counter access: control word, then high half, then low half.
module host_model
    import stat_pkg::*;
(
    // Clock
    input  wire logic        core_clk,
    // Indirect access port
    output logic             ctrl_wr,
    output logic [15:0]      ctrl_wdata,
    output logic             high_rd,
    output logic             low_rd,
    input  wire logic [15:0] high_half,
    input  wire logic [15:0] low_half
);
    initial
    begin
        ctrl_wr    = 1'b0;
        ctrl_wdata = 16'h0000;
        high_rd    = 1'b0;
        low_rd     = 1'b0;
    end

    task automatic read_cnt(input logic [9:0] addr, input logic flagged, output logic [15:0] early,
                            output logic [15:0] hi, output logic [15:0] lo, output logic ok);
        int tries;
        ok = 1'b0;
        hi = 16'h0000;
        @(posedge core_clk);
        ctrl_wr    <= 1'b1;
        ctrl_wdata <= {OP_READ_CNT, addr};
        @(posedge core_clk);
        ctrl_wr <= 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
        early = high_half;
        repeat (2) @(posedge core_clk);
        // high half is re-read while not valid; drop counters carry no flag.
        for (tries = 0; tries < 8 && !ok; tries++)
        begin
            high_rd <= 1'b1;
            @(posedge core_clk);
            high_rd <= 1'b0;
            @(negedge core_clk);
            hi = high_half;
            ok = !flagged || (hi[VALID_BIT] === 1'b1);
            @(posedge core_clk);
        end
        low_rd <= 1'b1;
        @(posedge core_clk);
        low_rd <= 1'b0;
        @(negedge core_clk);
        lo = low_half;
    endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
    import stat_pkg::*;
();
    localparam logic [31:0] vld = 32'h40000000;
    logic                   core_clk;
    logic                   reset;
    logic [PORTS-1:0]       rx_done, rx_crc_ok, rx_odd_bits, rx_sym_err, rx_bcast, rx_mcast, rx_pause_da;
    logic [PORTS*OCT_W-1:0] rx_len, tx_len;
    logic [PORTS*16-1:0]    rx_type, rx_opcode;
    logic [PORTS-1:0]       tx_done, tx_pause, tx_bcast, tx_mcast, tx_late_hit, tx_deferred;
    logic [PORTS-1:0]       tx_collision, half_duplex, tx_abandoned, tx_drop, rx_drop;
    logic [PORTS*4-1:0]     tx_hits;
    logic                   ctrl_wr, high_rd, low_rd;
    logic [15:0]            ctrl_wdata, indirect_data_high_half, indirect_data_low_half;
    int                     n_errors;
    int                     checked;

    port_statistics_counters dut_u (.core_clk, .reset, .rx_done, .rx_len, .rx_crc_ok, .rx_odd_bits,
        .rx_sym_err, .rx_bcast, .rx_mcast, .rx_pause_da, .rx_type, .rx_opcode, .tx_done, .tx_len,
        .tx_pause, .tx_bcast, .tx_mcast, .tx_late_hit, .tx_deferred, .tx_collision, .half_duplex,
        .tx_abandoned, .tx_hits, .tx_drop, .rx_drop, .ctrl_wr, .ctrl_wdata, .high_rd, .low_rd,
        .indirect_data_high_half, .indirect_data_low_half);

    host_model host_u (.core_clk, .ctrl_wr, .ctrl_wdata, .high_rd, .low_rd,
        .high_half(indirect_data_high_half), .low_half(indirect_data_low_half));

    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic summarize();
        if (n_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic chk(input logic [9:0] a, input logic [31:0] exp);
        logic [15:0] e, h, l;
        logic        ok;
        host_u.read_cnt(a, a <= PORT_LAST, e, h, l, ok);
        if (ok !== 1'b1)
        begin
            n_errors++;
            summarize();
        end
        check($sformatf("counter %h", a), {h, l}, exp);
        // valid flag low while the read is pending.
        if (a <= PORT_LAST) check("pending valid flag", {31'h0, e[VALID_BIT]}, 32'h0);
    endtask

    // Flags: crc_ok, odd_bits, sym_err, bcast, mcast, pause_da.
    task automatic rx(input int p, input logic [10:0] len, input logic [5:0] f, input logic [15:0] ty);
        @(posedge core_clk);
        rx_done[p]                 <= 1'b1;
        rx_len[p*OCT_W +: OCT_W]   <= len;
        {rx_crc_ok[p], rx_odd_bits[p], rx_sym_err[p], rx_bcast[p], rx_mcast[p], rx_pause_da[p]} <= f;
        rx_type[p*16 +: 16]        <= ty;
        rx_opcode[p*16 +: 16]      <= OPC_PAUSE;
        @(posedge core_clk);
        rx_done[p] <= 1'b0;
    endtask

    // Flags: pause, bcast, mcast, deferred.
    task automatic tx(input int p, input logic [10:0] len, input logic [3:0] f, input logic [3:0] hits);
        @(posedge core_clk);
        tx_done[p]               <= 1'b1;
        tx_len[p*OCT_W +: OCT_W] <= len;
        {tx_pause[p], tx_bcast[p], tx_mcast[p], tx_deferred[p]} <= f;
        tx_hits[p*4 +: 4]        <= hits;
        @(posedge core_clk);
        tx_done[p]        <= 1'b0;
        tx_hits[p*4 +: 4] <= 4'h0;
    endtask

    // Pulses: late, collision, abandoned, tx drop, rx drop.
    task automatic ev(input int p, input logic [4:0] m);
        @(posedge core_clk);
        {tx_late_hit[p], tx_collision[p], tx_abandoned[p], tx_drop[p], rx_drop[p]} <= m;
        @(posedge core_clk);
        {tx_late_hit[p], tx_collision[p], tx_abandoned[p], tx_drop[p], rx_drop[p]} <= 5'h00;
    endtask

    initial
    begin
        n_errors = 0;
        checked  = 0;
        reset    = 1'b1;
        {rx_done, rx_crc_ok, rx_odd_bits, rx_sym_err, rx_bcast, rx_mcast, rx_pause_da} = '0;
        {rx_len, tx_len, rx_type, rx_opcode, tx_hits} = '0;
        {tx_done, tx_pause, tx_bcast, tx_mcast, tx_late_hit, tx_deferred} = '0;
        {tx_collision, half_duplex, tx_abandoned, tx_drop, rx_drop} = '0;
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        chk(10'h000, vld); // Zero.
        chk(10'h03f, vld); // Zero.
        chk(DROP_TX1, 32'h0); // Zero.
        rx(0, 11'd64, 6'b100100, 16'h0800);
        rx(0, 11'd64, 6'b100011, TYPE_CTRL);
        rx(0, 11'd1600, 6'b100000, 16'h0800);
        rx(0, 11'd1600, 6'b000000, 16'h0800);
        rx(0, 11'd40, 6'b100000, 16'h0800);
        rx(0, 11'd40, 6'b000000, 16'h0800);
        rx(0, 11'd100, 6'b101000, 16'h0800);
        chk(10'h000, vld + 32'd3508); // Octets.
        chk(10'h000, vld); // Cleared.
        chk(10'h002, vld + 32'd1); // Short.
        chk(10'h003, vld + 32'd1); // Fragment.
        chk(10'h004, vld + 32'd1); // Oversize.
        chk(10'h005, vld + 32'd1); // Long bad.
        chk(10'h006, vld + 32'd1); // Symbol.
        chk(10'h009, vld + 32'd1); // Control.
        chk(10'h00a, vld + 32'd1); // Pause.
        chk(10'h00b, vld + 32'd1); // Broadcast.
        chk(10'h00c, vld); // Control excluded.
        chk(10'h00e, vld + 32'd2); // Bin.
        chk(10'h00f, vld + 32'd1); // Bin.
        chk(10'h013, vld + 32'd2); // Bin.
        rx(1, 11'd100, 6'b000000, 16'h0800);
        rx(1, 11'd200, 6'b010000, 16'h0800);
        rx(1, 11'd300, 6'b100000, 16'h0800);
        rx(1, 11'd600, 6'b100010, 16'h0800);
        chk(10'h020, vld + 32'd1200); // Octets.
        chk(10'h027, vld + 32'd1); // Whole bytes.
        chk(10'h028, vld + 32'd1); // Partial bytes.
        chk(10'h02b, vld); // No broadcast.
        chk(10'h02c, vld + 32'd1); // Multicast.
        chk(10'h02d, vld + 32'd1); // Unicast.
        chk(10'h02f, vld + 32'd1); // Bin.
        chk(10'h030, vld + 32'd1); // Bin.
        chk(10'h031, vld + 32'd1); // Bin.
        chk(10'h032, vld + 32'd1); // Bin.
        // transmit classes; collisions count only in half duplex.
        tx(0, 11'd200, 4'b0001, 4'd1);
        tx(0, 11'd64, 4'b1010, 4'd3);
        tx(0, 11'd100, 4'b0100, 4'd0);
        @(posedge core_clk);
        half_duplex <= 2'b01;
        ev(0, 5'b11100);
        @(posedge core_clk);
        half_duplex <= 2'b00;
        ev(0, 5'b01000);
        chk(10'h014, vld + 32'd364); // Octets.
        chk(10'h016, vld + 32'd1); // Late.
        chk(10'h017, vld + 32'd1); // Pause.
        chk(10'h018, vld + 32'd1); // Broadcast.
        chk(10'h019, vld + 32'd1); // Multicast.
        chk(10'h01a, vld + 32'd1); // Unicast.
        chk(10'h01b, vld + 32'd1); // Deferred.
        chk(10'h01c, vld + 32'd1); // Half duplex.
        chk(10'h01d, vld + 32'd1); // Abandoned.
        chk(10'h01e, vld + 32'd1); // One.
        chk(10'h01f, vld + 32'd1); // Many.
        ev(0, 5'b00010);
        ev(0, 5'b00010);
        ev(1, 5'b00001);
        chk(DROP_TX1, 32'd2); // Drops.
        chk(DROP_TX1, 32'd2); // Kept.
        chk(DROP_TX2, 32'd0); // None.
        chk(DROP_RX1, 32'd0); // None.
        chk(DROP_RX2, 32'd1); // Drops.
        chk(10'h102, 32'd0); // Unmapped.
        // A second reset clears counters that still hold counts.
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        chk(10'h007, vld); // Cleared by reset.
        chk(DROP_TX1, 32'h0); // Drops cleared.
        summarize();
    end
endmodule
`default_nettype wire
